/* src/eeprom_access_defines.vh */
// Register offsets, field positions, reset values and timing counts
// for the data EEPROM access controller.
// Assumes a 10 MHz system clock and an RC oscillator tick pin.
//
// Operation
// - Mode 00 atomic erase+write, 01 erase only, 10 write only, 11 reserved.
// - Writes to the mode field are ignored while programming is busy.
// - Reset clears the mode field unless programming is still running.
// - Ready request stays high while enabled, global enable set, not busy.
// - Program strobe starts a write only within four cycles of arming.
// - The arm bit clears itself four cycles after software sets it.
// - No EEPROM programming while flash self-programming is active.
// - Hardware clears the busy strobe flag when the write time ends.
// - A started write stalls the CPU for two cycles.
// - Read strobe loads the addressed byte into the data register at once.
// - A read stalls the CPU for four cycles.
// - While busy, reads are refused and address writes are ignored.
// - An atomic write is timed by 26,368 RC oscillator cycles, about 3.4 ms; erase only or write only by 13,959.
// - Address selects one of 512 bytes; upper address bits read zero.
// - Data register holds write data and receives read data.
`ifndef EEPROM_ACCESS_DEFINES_VH
`define EEPROM_ACCESS_DEFINES_VH

`define EE_OFS_CTRL    8'h00
`define EE_OFS_ADDR    8'h04
`define EE_OFS_DATA    8'h08
`define EE_OFS_STATUS  8'h0C

`define EE_BIT_READ    0
`define EE_BIT_PROG    1
`define EE_BIT_ARM     2
`define EE_BIT_RIE     3
`define EE_BIT_MODE_LO 4
`define EE_BIT_MODE_HI 5

`define EE_MODE_ATOMIC 2'h0
`define EE_MODE_ERASE  2'h1
`define EE_MODE_WRITE  2'h2
`define EE_MODE_RSVD   2'h3

`define EE_CTRL_RST    2'h0
`define EE_ERASED      8'hFF

`define EE_ARM_CYCLES  3'h4
`define EE_WR_STALL    3'h2
`define EE_RD_STALL    3'h4

`define EE_ATOMIC_US   3400
`define EE_SPLIT_US    1800
`define EE_WRITE_RC    26368
`define EE_SPLIT_RC    ((`EE_WRITE_RC * `EE_SPLIT_US) / `EE_ATOMIC_US)

`endif

/* src/prog_timer.v */
// Programming-time counter driven by RC oscillator edges.
// Assumes rcOscClk is asynchronous to sys_clk; only power-on reset stops it.
`timescale 1ns/1ps
module prog_timer #(
  parameter CNT_W = 15
) (
  input  wire             sys_clk,
  input  wire             porRst_n,
  input  wire             rcOscClk,
  input  wire             start,
  input  wire [CNT_W-1:0] loadCount,
  output reg              done
);
  reg             rcMetaQ;
  reg             rcSyncQ;
  reg             rcPrevQ;
  reg             runQ;
  reg [CNT_W-1:0] remainQ;

  wire rcEdge = rcSyncQ & ~rcPrevQ;

  always @(posedge sys_clk) begin
    if (!porRst_n) begin
      rcMetaQ <= 1'b0;
      rcSyncQ <= 1'b0;
      rcPrevQ <= 1'b0;
      runQ    <= 1'b0;
      remainQ <= {CNT_W{1'b0}};
      done    <= 1'b0;
    end else begin
      rcMetaQ <= rcOscClk;
      rcSyncQ <= rcMetaQ;
      rcPrevQ <= rcSyncQ;
      done    <= 1'b0;
      if (start) begin
        remainQ <= loadCount;
        runQ    <= 1'b1;
      end else if (runQ && rcEdge) begin
        if (remainQ <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
          runQ    <= 1'b0;
          remainQ <= {CNT_W{1'b0}};
          done    <= 1'b1;
        end else begin
          remainQ <= remainQ - {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // prog_timer

/* src/eeprom_store.v */
// Byte array standing in for the nonvolatile cells.
// Assumes the controller issues at most one program pulse per operation.
`timescale 1ns/1ps
`include "eeprom_access_defines.vh"
module eeprom_store #(
  parameter DEPTH  = 512,
  parameter ADDR_W = 9
) (
  input  wire              sys_clk,
  input  wire [ADDR_W-1:0] rdAddr,
  output wire [7:0]        rdData,
  input  wire              wrEn,
  input  wire [ADDR_W-1:0] wrAddr,
  input  wire [7:0]        wrData,
  input  wire [1:0]        wrMode
);
  reg [7:0] cells [0:DEPTH-1];

  assign rdData = cells[rdAddr];

  always @(posedge sys_clk) begin
    if (wrEn) begin
      case (wrMode)
        `EE_MODE_ATOMIC: cells[wrAddr] <= wrData;
        `EE_MODE_ERASE:  cells[wrAddr] <= `EE_ERASED;
        `EE_MODE_WRITE:  cells[wrAddr] <= cells[wrAddr] & wrData;
        default:         cells[wrAddr] <= cells[wrAddr];
      endcase
    end
  end
endmodule // eeprom_store

/* src/eeprom_access_control.v */
// Data EEPROM access controller with an AHB-Lite register slave.
// Assumes one AHB-Lite master, single word transfers, and that
// flashSelfprogBusy and globalIrqEnable come from logic on sys_clk.
//
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "eeprom_access_defines.vh"
module eeprom_access_control #(
  parameter        DEPTH     = 512,
  parameter        ADDR_W    = 9,
  parameter        CNT_W     = 15,
  parameter [14:0] ATOMIC_RC = `EE_WRITE_RC,
  parameter [14:0] SPLIT_RC  = `EE_SPLIT_RC
) (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        porRst_n,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  input  wire        rcOscClk,
  input  wire        flashSelfprogBusy,
  input  wire        globalIrqEnable,
  output wire        readyIrq,
  output wire        cpuStall
);
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_PROG = 2'b10;

  // Bus data phase tracking
  reg              pendQ;
  reg              pendWrQ;
  reg [7:0]        pendOfsQ;
  reg [2:0]        pendSizeQ;
  reg [31:0]       hrdataQ;

  // Software-visible control state
  reg [1:0]        modeQ;
  reg              irqEnQ;
  reg [2:0]        armCntQ;
  reg [ADDR_W-1:0] addrQ;
  reg [7:0]        dataQ;
  reg [2:0]        stallCntQ;

  // Programming engine, survives system reset
  reg [1:0]        stateQ;
  reg [1:0]        opModeQ;
  reg [ADDR_W-1:0] opAddrQ;
  reg [7:0]        opDataQ;

  wire [7:0]       storeRdData;
  wire             timerDone;
  wire             busy;
  wire             armed;
  wire             wrCommit;
  wire             ctrlWr;
  wire             addrWr;
  wire             dataWr;
  wire [1:0]       wrModeField;
  wire             progReq;
  wire             readReq;
  wire             progDone;
  wire             acceptPhase;
  reg  [CNT_W-1:0] opCount;

  function [31:0] regRead;
    input [7:0] ofs;
    begin
      case (ofs)
        `EE_OFS_CTRL:
          regRead = {24'h000000, 2'h0, modeQ, irqEnQ, armed, busy,
                     1'b0};
        `EE_OFS_ADDR:
          regRead = {{(32-ADDR_W){1'b0}}, addrQ};
        `EE_OFS_DATA:
          regRead = {24'h000000, dataQ};
        `EE_OFS_STATUS:
          regRead = {28'h0000000, readyIrq, flashSelfprogBusy,
                     cpuStall, busy};
        default:
          regRead = 32'h00000000;
      endcase
    end
  endfunction

  function isOfs;
    input [7:0] ofs;
    input [7:0] want;
    begin
      isOfs = (ofs == want);
    end
  endfunction

  // Status and handshakes
  assign busy        = (stateQ == ST_PROG);
  assign armed       = (armCntQ != 3'h0);
  assign hreadyout   = (stallCntQ == 3'h0);
  assign cpuStall    = (stallCntQ != 3'h0);
  assign hresp       = 1'b0;
  assign hrdata      = hrdataQ;
  assign readyIrq    = irqEnQ & globalIrqEnable & ~busy;

  // Bus decode
  assign acceptPhase = hsel & htrans[1] & hready;
  assign wrCommit    = pendQ & pendWrQ & hreadyout;
  assign ctrlWr      = wrCommit & isOfs(pendOfsQ, `EE_OFS_CTRL);
  assign addrWr      = wrCommit & isOfs(pendOfsQ, `EE_OFS_ADDR);
  assign dataWr      = wrCommit & isOfs(pendOfsQ, `EE_OFS_DATA);
  assign wrModeField = hwdata[`EE_BIT_MODE_HI:`EE_BIT_MODE_LO];

  // Start conditions
  assign progReq = ctrlWr & hwdata[`EE_BIT_PROG] & ~busy
                   & armed
                   & ~flashSelfprogBusy
                   & (wrModeField != `EE_MODE_RSVD);
  assign readReq = ctrlWr & hwdata[`EE_BIT_READ] & ~busy
                   & ~progReq;
  assign progDone = busy & timerDone;

  always @* begin
    if (wrModeField == `EE_MODE_ATOMIC) begin
      opCount = ATOMIC_RC;
    end else begin
      opCount = SPLIT_RC;
    end
  end

  // AHB-Lite address and data phase tracking
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      pendQ     <= 1'b0;
      pendWrQ   <= 1'b0;
      pendOfsQ  <= 8'h00;
      pendSizeQ <= 3'h0;
      hrdataQ   <= 32'h00000000;
    end else begin
      if (hreadyout) begin
        pendQ <= acceptPhase;
        if (acceptPhase) begin
          pendWrQ   <= hwrite;
          pendOfsQ  <= haddr[7:0];
          pendSizeQ <= hsize;
          hrdataQ   <= regRead(haddr[7:0]);
        end
      end else if (pendQ) begin
        hrdataQ <= regRead(pendOfsQ);
      end
    end
  end

  // Mode field and ready enable
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      if (!busy) begin
        modeQ <= `EE_CTRL_RST;
      end
      irqEnQ <= 1'b0;
    end else if (ctrlWr) begin
      if (!busy) begin
        modeQ <= wrModeField;
      end
      irqEnQ <= hwdata[`EE_BIT_RIE];
    end
  end

  // Arm window
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      armCntQ <= 3'h0;
    end else if (progReq) begin
      armCntQ <= 3'h0;
    end else if (ctrlWr && hwdata[`EE_BIT_ARM]) begin
      armCntQ <= `EE_ARM_CYCLES;
    end else if (armCntQ != 3'h0) begin
      armCntQ <= armCntQ - 3'h1;
    end
  end

  // CPU stall counter
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      stallCntQ <= 3'h0;
    end else if (progReq) begin
      stallCntQ <= `EE_WR_STALL;
    end else if (readReq) begin
      stallCntQ <= `EE_RD_STALL;
    end else if (stallCntQ != 3'h0) begin
      stallCntQ <= stallCntQ - 3'h1;
    end
  end

  // Address and data registers
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      addrQ <= {ADDR_W{1'b0}};
      dataQ <= 8'h00;
    end else begin
      if (addrWr && !busy) begin
        addrQ <= hwdata[ADDR_W-1:0];
      end
      if (readReq) begin
        dataQ <= storeRdData;
      end else if (dataWr) begin
        dataQ <= hwdata[7:0];
      end
    end
  end

  // Programming engine
  always @(posedge sys_clk) begin
    if (!porRst_n) begin
      stateQ  <= ST_IDLE;
      opModeQ <= `EE_MODE_ATOMIC;
      opAddrQ <= {ADDR_W{1'b0}};
      opDataQ <= 8'h00;
    end else begin
      case (stateQ)
        ST_IDLE: begin
          if (progReq) begin
            stateQ  <= ST_PROG;
            opModeQ <= wrModeField;
            opAddrQ <= addrQ;
            opDataQ <= dataQ;
          end
        end
        ST_PROG: begin
          if (timerDone) begin
            stateQ <= ST_IDLE;
          end
        end
        default: begin
          stateQ <= ST_IDLE;
        end
      endcase
    end
  end

  prog_timer #(
    .CNT_W     (CNT_W)
  ) u_timer (
    .sys_clk   (sys_clk),
    .porRst_n  (porRst_n),
    .rcOscClk  (rcOscClk),
    .start     (progReq),
    .loadCount (opCount),
    .done      (timerDone)
  );

  eeprom_store #(
    .DEPTH  (DEPTH),
    .ADDR_W (ADDR_W)
  ) u_store (
    .sys_clk (sys_clk),
    .rdAddr  (addrQ),
    .rdData  (storeRdData),
    .wrEn    (progDone),
    .wrAddr  (opAddrQ),
    .wrData  (opDataQ),
    .wrMode  (opModeQ)
  );
endmodule // eeprom_access_control

/* verification/eeprom_access_control_assertions.sv */
// Port checks for the EEPROM access controller.
// Bound to every eeprom_access_control instance.
`timescale 1ns/1ps
module eeprom_access_control_assertions (
  input wire        sys_clk,
  input wire        rst_n,
  input wire        hresp,
  input wire        hreadyout,
  input wire [31:0] hrdata,
  input wire        globalIrqEnable,
  input wire        readyIrq,
  input wire        cpuStall
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence wrStall;
    $rose(cpuStall) ##1 cpuStall ##1 !cpuStall;
  endsequence
  a_resp_okay: assert property (!hresp)
    else $error("hresp not OKAY");
  a_stall_ready: assert property (cpuStall == !hreadyout)
    else $error("stall and hreadyout disagree");
  a_irq_needs_gie: assert property (!globalIrqEnable |-> !readyIrq)
    else $error("irq without global enable");
  a_addr_upper_zero: assert property (hrdata[31:9] == 23'h0)
    else $error("upper read bits set");
  a_stall_min: assert property ($rose(cpuStall) |-> cpuStall[*2])
    else $error("stall shorter than two cycles");
  a_stall_max: assert property ($rose(cpuStall) |-> ##[2:4] !cpuStall)
    else $error("stall longer than four cycles");
  a_stall_gap: assert property ($fell(cpuStall) |=> !cpuStall)
    else $error("stall restarted without a transfer");
  a_irq_write_busy: assert property (wrStall |-> !readyIrq)
    else $error("ready irq while writing");
  c_write: cover property (wrStall);
  c_read: cover property ($rose(cpuStall) ##1 cpuStall[*3] ##1 !cpuStall);
  c_irq: cover property ($rose(readyIrq));
endmodule // eeprom_access_control_assertions

bind eeprom_access_control eeprom_access_control_assertions chk_u (
  .sys_clk(sys_clk), .rst_n(rst_n), .hresp(hresp), .hreadyout(hreadyout),
  .hrdata(hrdata), .globalIrqEnable(globalIrqEnable),
  .readyIrq(readyIrq), .cpuStall(cpuStall));

/* verification/cpu_bus_model.sv */
// AHB-Lite master standing in for the CPU's register accesses.
// Assumes hready is the slave's hreadyout; single word transfers.
`timescale 1ns/1ps
module cpu_bus_model (
  input  wire         sys_clk,
  input  wire         hready,
  input  wire  [31:0] hrdata,
  output logic        hsel,
  output logic [31:0] haddr,
  output logic [1:0]  htrans,
  output logic        hwrite,
  output logic [2:0]  hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    r = hrdata;
    hwdata <= ~d;  // Released data stops showing the last word
  endtask
endmodule // cpu_bus_model

/* verification/tb_top.sv */
// Self-checking bench for the EEPROM access controller.
// Uses cpu_bus_model as bus master; write counts shortened.
`timescale 1ns/1ps
`include "eeprom_access_defines.vh"
module tb_top;
  logic        sys_clk, rst_n, porRst_n, rcOscClk, flashBusy, gie;
  wire         hsel, hwrite, hreadyout, hresp, readyIrq, cpuStall;
  wire  [1:0]  htrans;
  wire  [2:0]  hsize;
  wire  [31:0] haddr, hwdata, hrdata;
  logic [31:0] rd;
  int          error_cnt = 0;
  int          n_checks = 0;
  typedef struct {logic [7:0] a; logic [31:0] w, e;} row_t;
  row_t rows[4] = '{'{`EE_OFS_ADDR, 32'hFFFF, 32'h1FF},
    '{`EE_OFS_DATA, 32'h1A5, 32'hA5}, '{`EE_OFS_CTRL, 32'h28, 32'h28},
    '{8'h10, 32'hFF, 32'h0}};
  logic [7:0] md[4] = '{8'h3C, 8'h00, 8'h5A, 8'h00};
  logic [7:0] mx[4] = '{8'h3C, 8'hFF, 8'h5A, 8'h5A};
  eeprom_access_control #(.ATOMIC_RC(15'h8), .SPLIT_RC(15'h4)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .porRst_n(porRst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .rcOscClk(rcOscClk),
    .flashSelfprogBusy(flashBusy), .globalIrqEnable(gie),
    .readyIrq(readyIrq), .cpuStall(cpuStall));
  cpu_bus_model cpu_u (
    .sys_clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    cpu_u.acc(1'b1, a, d, rd);
  endtask
  task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    cpu_u.acc(1'b0, a, 32'h0, rd);
    chk(n, e, rd);
  endtask
  task prog(input logic [1:0] m, input logic [7:0] d);
    wr(`EE_OFS_DATA, {24'h0, d});
    wr(`EE_OFS_CTRL, 32'hC);
    wr(`EE_OFS_CTRL, {26'h0, m, 4'hA});
  endtask
  task waitIdle;
    do cpu_u.acc(1'b0, `EE_OFS_STATUS, 32'h0, rd);
    while (rd[0] !== 1'b0);
  endtask
  task conclude;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    rcOscClk = 1'b0;
    forever #250 rcOscClk = ~rcOscClk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    conclude;
  end
  initial begin
    {rst_n, porRst_n, flashBusy, gie} = 4'h0;
    repeat (10) @(posedge sys_clk);
    {rst_n, porRst_n} <= 2'h3;
    rdc("rst", `EE_OFS_CTRL, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rdc("reg", rows[i].a, rows[i].e);
    end
    gie <= 1'b1;
    @(negedge sys_clk) chk("irq", 32'h1, {31'h0, readyIrq});
    wr(`EE_OFS_ADDR, 32'h5);
    for (int i = 0; i < 4; i++) begin
      prog(i[1:0], md[i]);
      rdc("busy", `EE_OFS_STATUS, i != 3 ? 32'h1 : 32'h8);
      if (i == 0) begin
        wr(`EE_OFS_ADDR, 32'h9);
        rdc("addr", `EE_OFS_ADDR, 32'h5);
        wr(`EE_OFS_CTRL, 32'h38);
      end
      waitIdle;
      if (i == 0) rdc("mode", `EE_OFS_CTRL, 32'h8);
      wr(`EE_OFS_CTRL, 32'h9);
      rdc("cell", `EE_OFS_DATA, {24'h0, mx[i]});
    end
    flashBusy <= 1'b1;
    prog(2'h0, 8'h11);
    rdc("flash", `EE_OFS_STATUS, 32'hC);
    flashBusy <= 1'b0;
    wr(`EE_OFS_CTRL, 32'h4);
    rdc("arm", `EE_OFS_CTRL, 32'h4);
    repeat (4) @(posedge sys_clk);
    rdc("armEnd", `EE_OFS_CTRL, 32'h0);
    wr(`EE_OFS_CTRL, 32'h2);
    rdc("late", `EE_OFS_STATUS, 32'h0);
    prog(2'h2, 8'h0);
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    rst_n <= 1'b1;
    rdc("rstBusy", `EE_OFS_CTRL, 32'h22);
    waitIdle;
    conclude;
  end
endmodule // tb_top
